// *** logic/extended_instruction_exec.sv ***
// Executor for the optional extended instructions of an 8-bit core.
// Assumes one instruction word on INSTR_WORD per four-clock instruction
// cycle, sampled at phase 0, and a data memory answering a read strobe
// with data in the following clock.
`timescale 1ns/1ns
`include "ext_exec_consts.svh"
module extended_instruction_exec
   import ext_exec_pkg::*;
#(
   parameter logic [13:0] IND_LO = `IND_LO_DEF,
   parameter logic [13:0] IND_HI = `IND_HI_DEF
) (
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic EXT_ENABLE,
   input wire logic [15:0] INSTR_WORD,
   input wire logic BRANCH_TAKEN,
   input wire logic [20:0] RETURN_STACK_TOP,
   input wire logic [7:0] MEM_RDATA,
   input wire logic FP_LOAD,
   input wire logic [13:0] FP_DATA,
   input wire logic [7:0] FILE_OPERAND,
   input wire logic ACCESS_BIT,
   output logic [1:0] INSTR_PHASE,
   output logic [13:0] MEM_ADDR,
   output logic [7:0] MEM_WDATA,
   output logic MEM_WE,
   output logic MEM_RE,
   output logic PC_LOAD,
   output logic [20:0] PC_VALUE,
   output logic [13:0] FRAME_POINTER,
   output logic STD_PASS,
   output logic NOP_CYCLE,
   output logic INDEXED_HIT,
   output logic [13:0] INDEXED_ADDR,
   output logic EXT_ACTIVE
);

   // -------------------------------------------------------------
   // Elaboration check
   // -------------------------------------------------------------
   // The indirect register window must not be empty.
   if (IND_LO > IND_HI) begin : g_bad_window
      $error("Indirect register window is inverted.");
   end

   // -------------------------------------------------------------
   // State and decode
   // -------------------------------------------------------------
   exec_state_t s_r;
   exec_state_t s_nxt;
   logic is_add;
   logic is_sub;
   logic is_push;
   logic is_sf;
   logic is_ss;
   logic is_sfl;
   logic [13:0] src_sum;
   logic [13:0] short_addr;

   // Tells whether an address selects an indirect addressing register.
   function automatic logic is_ind(input logic [13:0] a);
      is_ind = (a >= IND_LO) && (a <= IND_HI);
   endfunction

   // Opcode matches on the held word, gated by the synced enable bit.
   assign is_add = s_r.ext_s2 &&
      ((s_r.cur & `OPM_ULNK) == `OP_ADDRET);
   assign is_sub = s_r.ext_s2 && ((s_r.cur & `OPM_ULNK) == `OP_SUBRET);
   assign is_push = s_r.ext_s2 && ((s_r.cur & `OPM_PUSH) == `OP_PUSH);
   assign is_sf = s_r.ext_s2 && ((s_r.cur & `OPM_MOVE) == `OP_IDX_FILE);
   assign is_ss = s_r.ext_s2 && ((s_r.cur & `OPM_MOVE) == `OP_IDX_IDX);
   assign is_sfl = s_r.ext_s2 && (s_r.cur == `OP_IDX_LONG);

   // Pointer plus the 7-bit offset; the short form drops bank bits.
   assign src_sum = s_r.fp + {7'h00, s_r.cur[6:0]};
   assign short_addr = {2'b00, src_sum[11:0]};

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   // One pass over the phase counter; strobes last one clock.
   always_comb begin
      s_nxt = s_r;
      s_nxt.q = s_r.q + 2'h1;
      s_nxt.ext_s1 = EXT_ENABLE;
      s_nxt.ext_s2 = s_r.ext_s1;
      s_nxt.mem_we = 1'b0;
      s_nxt.mem_re = 1'b0;
      s_nxt.pc_load = 1'b0;
      s_nxt.std_pass = 1'b0;
      // Standard operands at or below the limit become pointer offsets.
      s_nxt.idx_hit = s_r.ext_s2 && !ACCESS_BIT &&
         (FILE_OPERAND <= `IDX_LIMIT);
      s_nxt.idx_addr = s_r.fp + {6'h00, FILE_OPERAND};
      if (FP_LOAD) begin
         s_nxt.fp = FP_DATA;
      end
      if (BRANCH_TAKEN) begin
         s_nxt.flush = 1'b1;
      end
      unique case (s_r.q)
         2'h0: begin
            // Latch the word; a pending flush turns this cycle to NOP.
            s_nxt.cur = INSTR_WORD;
            s_nxt.dead = s_r.flush;
            s_nxt.flush = BRANCH_TAKEN;
         end
         `Q_DEC: begin
            s_nxt.op = OP_NONE;
            s_nxt.src_zero = 1'b0;
            if (!s_r.dead) begin
               unique case (s_r.st)
                  S_DEC: begin
                     if (is_add) begin
                        s_nxt.op = OP_ADD;
                     end else if (is_sub) begin
                        s_nxt.op = OP_SUB;
                     end else if (is_push) begin
                        // Literal goes to the address in the pointer.
                        s_nxt.op = OP_PUSH;
                        s_nxt.mem_addr = s_r.fp;
                        s_nxt.mem_wdata = s_r.cur[7:0];
                        s_nxt.mem_we = 1'b1;
                     end else if (is_sf || is_ss) begin
                        // Source read ends within the first cycle.
                        s_nxt.op = is_sf ? OP_SF : OP_SS;
                        s_nxt.mem_addr = short_addr;
                        s_nxt.mem_re = 1'b1;
                        s_nxt.rd_pend = 1'b1;
                        s_nxt.src_zero = is_ss && is_ind(short_addr);
                     end else if (is_sfl) begin
                        s_nxt.op = OP_SFL;
                     end else if (s_r.cur[15:12] != `OPERAND_NIB) begin
                        // Operand-shaped words fall through as NOP.
                        s_nxt.std_pass = 1'b1;
                     end
                  end
                  S_SFL2: begin
                     // Full-width source sum, read in the second cycle.
                     s_nxt.mem_addr = s_r.fp +
                        {7'h00, s_r.cur[8:2]};
                     s_nxt.mem_re = 1'b1;
                     s_nxt.rd_pend = 1'b1;
                     s_nxt.src_zero = is_ind(s_r.fp +
                        {7'h00, s_r.cur[8:2]});
                     s_nxt.dhi = s_r.cur[1:0];
                  end
                  default: begin
                  end
               endcase
            end
         end
         `Q_WR: begin
            // Writes show in the last phase of their cycle.
            unique case (s_r.st)
               S_SF2: begin
                  s_nxt.mem_addr = {2'b00, s_r.cur[11:0]};
                  s_nxt.mem_wdata = s_r.data;
                  s_nxt.mem_we = !s_r.dead;
               end
               S_SS2: begin
                  s_nxt.mem_addr = {2'b00, src_sum[11:0]};
                  s_nxt.mem_wdata = s_r.data;
                  // An indirect destination suppresses the write.
                  s_nxt.mem_we = !s_r.dead &&
                     !is_ind({2'b00, src_sum[11:0]});
               end
               S_SFL3: begin
                  // Software keeps PC and stack bytes out of this target.
                  s_nxt.mem_addr = {s_r.dhi, s_r.cur[11:0]};
                  s_nxt.mem_wdata = s_r.data;
                  s_nxt.mem_we = !s_r.dead;
               end
               default: begin
               end
            endcase
         end
         `Q_END: begin
            // Capture read data; indirect sources give zero, except in the indexed-to-file move.
            if (s_r.rd_pend) begin
               s_nxt.rd_pend = 1'b0;
               s_nxt.data = s_r.src_zero ? 8'h00 : MEM_RDATA;
            end
            s_nxt.st = S_DEC;
            unique case (s_r.op)
               OP_ADD: begin
                  s_nxt.fp = s_r.fp + {8'h00, s_r.cur[5:0]};
                  s_nxt.pc_load = 1'b1;
                  s_nxt.pc_value = RETURN_STACK_TOP;
                  s_nxt.flush = 1'b1;
               end
               OP_SUB: begin
                  s_nxt.fp = s_r.fp - {8'h00, s_r.cur[5:0]};
                  s_nxt.pc_load = 1'b1;
                  s_nxt.pc_value = RETURN_STACK_TOP;
                  s_nxt.flush = 1'b1;
               end
               OP_PUSH: begin
                  s_nxt.fp = s_r.fp - 14'h0001;
               end
               OP_SF: begin
                  s_nxt.st = S_SF2;
               end
               OP_SS: begin
                  s_nxt.st = S_SS2;
               end
               OP_SFL: begin
                  s_nxt.st = S_SFL2;
               end
               OP_NONE: begin
                  if (s_r.st == S_SFL2 && !s_r.dead) begin
                     s_nxt.st = S_SFL3;
                  end
               end
               default: begin
               end
            endcase
         end
      endcase
   end

   // The whole state registers at once; reset gives all zeros.
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // Every output is a field of the registered state.
   assign INSTR_PHASE = s_r.q;
   assign MEM_ADDR = s_r.mem_addr;
   assign MEM_WDATA = s_r.mem_wdata;
   assign MEM_WE = s_r.mem_we;
   assign MEM_RE = s_r.mem_re;
   assign PC_LOAD = s_r.pc_load;
   assign PC_VALUE = s_r.pc_value;
   assign FRAME_POINTER = s_r.fp;
   assign STD_PASS = s_r.std_pass;
   assign NOP_CYCLE = s_r.dead;
   assign INDEXED_HIT = s_r.idx_hit;
   assign INDEXED_ADDR = s_r.idx_addr;
   assign EXT_ACTIVE = s_r.ext_s2;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);

   sequence sf_read;
      s_r.op == OP_SF && s_r.q == `Q_WR && s_r.mem_re;
   endsequence
   sequence sf_write;
      s_r.mem_we && s_r.st == S_SF2 && s_r.mem_addr[13:12] == 2'b00;
   endsequence
   sequence ret_start;
      s_r.q == `Q_END && (s_r.op == OP_ADD || s_r.op == OP_SUB);
   endsequence

   a_ext_gate_off: assert property (
      (s_r.q == `Q_DEC && !s_r.ext_s2) |=> s_r.op == OP_NONE)
      else $error("Extended opcode decoded while disabled.");
   a_push_store_dec: assert property (
      (s_r.op == OP_PUSH && s_r.q == `Q_WR && s_r.mem_we && !FP_LOAD)
      |-> (s_r.mem_addr == s_r.fp) ##2 (s_r.fp == $past(s_r.fp, 2)
      - 14'h0001))
      else $error("Push did not store then decrement.");
   a_ret_nop_cycle: assert property (
      ret_start |=> s_r.pc_load ##1 s_r.dead)
      else $error("Return without following NOP cycle.");
   a_add_frame_sum: assert property (
      (s_r.op == OP_ADD && s_r.q == `Q_END && !FP_LOAD) |=>
      s_r.fp == $past(s_r.fp) + {8'h00, $past(s_r.cur[5:0])})
      else $error("Frame pointer add is wrong.");
   a_sub_frame_diff: assert property (
      (s_r.op == OP_SUB && s_r.q == `Q_END && !FP_LOAD) |=>
      s_r.fp == $past(s_r.fp) - {8'h00, $past(s_r.cur[5:0])})
      else $error("Frame pointer subtract is wrong.");
   a_sf_two_cycle: assert property (
      sf_read ##5 (!s_r.dead) |-> sf_write)
      else $error("Short move did not write in second cycle.");
   a_long_three_cyc: assert property (
      (s_r.op == OP_SFL && s_r.q == `Q_END) |=> s_r.st == S_SFL2
      ##4 s_r.st == S_SFL3 ##4 s_r.st == S_DEC)
      else $error("Long move did not take three cycles.");
   a_ind_src_zero: assert property (
      (s_r.q == `Q_END && s_r.rd_pend && s_r.src_zero) |=>
      s_r.data == 8'h00)
      else $error("Indirect source did not give zero.");
   a_ss_ind_nowr: assert property (
      (s_r.st == S_SS2 && s_r.q == `Q_WR &&
      is_ind({2'b00, src_sum[11:0]})) |=> !s_r.mem_we)
      else $error("Indirect destination was written.");
   a_branch_nop: assert property (
      (BRANCH_TAKEN && s_r.q == `Q_DEC) |-> ##4 s_r.dead)
      else $error("Branch did not add a NOP cycle.");
   a_operand_nop: assert property (
      (s_r.q == `Q_DEC && s_r.st == S_DEC && !s_r.dead &&
      s_r.cur[15:12] == `OPERAND_NIB) |=> !s_r.std_pass &&
      s_r.op == OP_NONE)
      else $error("Operand word not executed as NOP.");
   a_idx_map: assert property (
      (s_r.ext_s2 && !ACCESS_BIT && FILE_OPERAND <= `IDX_LIMIT) |=>
      s_r.idx_hit)
      else $error("Indexed operand not remapped.");

endmodule

// *** logic/ext_exec_consts.svh ***
// Constants for the extended instruction executor.
// Assumes inclusion by its bare name from the package and the executor.
`ifndef EXT_EXEC_CONSTS_SVH
`define EXT_EXEC_CONSTS_SVH
`define OPM_ULNK 16'hFFC0
`define OP_ADDRET 16'hE8C0
`define OP_SUBRET 16'hE9C0
`define OPM_PUSH 16'hFF00
`define OP_PUSH 16'hEA00
`define OPM_MOVE 16'hFF80
`define OP_IDX_FILE 16'hEB00
`define OP_IDX_IDX 16'hEB80
`define OP_IDX_LONG 16'h0002
`define OPERAND_NIB 4'hF
`define IDX_LIMIT 8'h5F
`define Q_DEC 2'h1
`define Q_WR 2'h2
`define Q_END 2'h3
`define IND_LO_DEF 14'h3FE0
`define IND_HI_DEF 14'h3FEF
`endif

// *** logic/ext_exec_pkg.sv ***
// Types for the extended instruction executor.
// Assumes the constants header is on the include path.
package ext_exec_pkg;
   `include "ext_exec_consts.svh"
   typedef enum logic [2:0] {
      S_DEC, S_SF2, S_SS2, S_SFL2, S_SFL3
   } seq_state_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_ADD, OP_SUB, OP_PUSH, OP_SF, OP_SS, OP_SFL
   } ext_op_t;
   typedef struct packed {
      logic [1:0] q;
      logic ext_s1;
      logic ext_s2;
      seq_state_t st;
      ext_op_t op;
      logic [15:0] cur;
      logic dead;
      logic flush;
      logic [13:0] fp;
      logic [7:0] data;
      logic rd_pend;
      logic src_zero;
      logic [1:0] dhi;
      logic [13:0] mem_addr;
      logic [7:0] mem_wdata;
      logic mem_we;
      logic mem_re;
      logic pc_load;
      logic [20:0] pc_value;
      logic std_pass;
      logic idx_hit;
      logic [13:0] idx_addr;
   } exec_state_t;
endpackage

// *** verification/ext_data_mem_model.sv ***
// Data memory model on the far side of the executor's data bus.
// Assumes one-clock read and write strobes sampled on the rising edge.
`timescale 1ns/1ns
module ext_data_mem_model (
   input wire logic clock,
   input wire logic mem_re,
   input wire logic mem_we,
   input wire logic [13:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   // ----------------------------------------------------------
   // Storage and bus answer
   // ----------------------------------------------------------
   logic [7:0] mem [int];
   logic re, we;
   logic [13:0] a;
   logic [7:0] wd;
   logic [7:0] rd_q = 8'h00;

   // Preloads one byte on behalf of the bench.
   function automatic void poke(input logic [13:0] a0, input logic [7:0] d0);
      mem[a0] = d0;
   endfunction

   // Read data stands for the one clock after the strobe; otherwise the
   // released bus toggles so a sample one clock late sees inverted data.
   always @(posedge clock) begin
      re = mem_re;
      we = mem_we;
      a = mem_addr;
      wd = mem_wdata;
      #1;
      if (re === 1'b1) rd_q = mem.exists(a) ? mem[a] : 8'hA5;
      else rd_q = ~rd_q;
      if (we === 1'b1) mem[a] = wd;
   end

   // The bus answer is driven from one place only.
   assign mem_rdata = rd_q;
endmodule

// *** verification/extended_instruction_exec_tb_top.sv ***
// Self-checking bench for the extended instruction executor.
// Assumes the package, the executor and the memory model compile first.
`timescale 1ns/1ns
module extended_instruction_exec_tb_top;
   import ext_exec_pkg::*;
   // ----------------------------------------------------------
   // Signals and model state
   // ----------------------------------------------------------
   logic CLOCK = 0, RESETN = 0, EXT_ENABLE = 0, BRANCH_TAKEN = 0;
   logic FP_LOAD = 0, ACCESS_BIT = 0;
   logic [15:0] INSTR_WORD = 16'hF000;
   logic [20:0] RETURN_STACK_TOP = 21'h0;
   logic [13:0] FP_DATA = 14'h0;
   logic [7:0] FILE_OPERAND = 8'h00;
   wire logic [7:0] MEM_RDATA;
   logic [1:0] INSTR_PHASE;
   logic [13:0] MEM_ADDR, FRAME_POINTER, INDEXED_ADDR;
   logic [7:0] MEM_WDATA;
   logic [20:0] PC_VALUE;
   logic MEM_WE, MEM_RE, PC_LOAD, STD_PASS, NOP_CYCLE, INDEXED_HIT;
   logic EXT_ACTIVE, nop_seen;
   int errors = 0, num_checks = 0, seed = 73, icyc = 0, nstd = 0;
   int xstd = 0, n, m, i;
   logic [13:0] fp = 14'h0, a, b;
   logic [6:0] zs, zd;
   logic [31:0] r;
   logic [39:0] xw[$], xr[$], xp[$], aw[$], ar[$], ap[$];
   logic [7:0] mdl [int];

   always #5 CLOCK = ~CLOCK;

   // Indirect registers are placed inside the lowest 4k for reach.
   extended_instruction_exec #(.IND_LO(14'h0FE0), .IND_HI(14'h0FEF)) i_dut (
      .CLOCK(CLOCK), .RESETN(RESETN), .EXT_ENABLE(EXT_ENABLE),
      .INSTR_WORD(INSTR_WORD), .BRANCH_TAKEN(BRANCH_TAKEN),
      .RETURN_STACK_TOP(RETURN_STACK_TOP), .MEM_RDATA(MEM_RDATA),
      .FP_LOAD(FP_LOAD), .FP_DATA(FP_DATA), .FILE_OPERAND(FILE_OPERAND),
      .ACCESS_BIT(ACCESS_BIT), .INSTR_PHASE(INSTR_PHASE),
      .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE),
      .MEM_RE(MEM_RE), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
      .FRAME_POINTER(FRAME_POINTER), .STD_PASS(STD_PASS),
      .NOP_CYCLE(NOP_CYCLE), .INDEXED_HIT(INDEXED_HIT),
      .INDEXED_ADDR(INDEXED_ADDR), .EXT_ACTIVE(EXT_ACTIVE));

   ext_data_mem_model i_mem (.clock(CLOCK), .mem_re(MEM_RE),
      .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
      .mem_rdata(MEM_RDATA));

   // Records writes, reads and returns with their instruction cycle number; counts standard passes and flags NOPs.
   always @(posedge CLOCK) begin
      #2;
      if (INSTR_PHASE === 2'h0) icyc++;
      if (MEM_WE === 1'b1) begin
         aw.push_back({icyc[15:0], 2'b0, MEM_ADDR, MEM_WDATA});
      end
      if (MEM_RE === 1'b1) ar.push_back({icyc[15:0], 2'b0, MEM_ADDR, 8'h00});
      if (PC_LOAD === 1'b1) ap.push_back({icyc[15:0], 3'b0, PC_VALUE});
      if (STD_PASS === 1'b1) nstd++;
      if (NOP_CYCLE === 1'b1) nop_seen = 1;
   end

   // ----------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------
   task automatic chk(input logic [39:0] act, exp, input string s);
      num_checks++;
      if (act !== exp) begin
         errors++;
         $display("ERROR %0t %s got %h want %h", $time, s, act, exp);
      end
   endtask

   task automatic cmpq(ref logic [39:0] q[$], x[$], input string s);
      chk(q.size(), x.size(), s);
      while (q.size() > 0 && x.size() > 0) begin
         chk(q.pop_front(), x.pop_front(), s);
      end
      q.delete();
      x.delete();
   endtask

   // Presents one word in phase 0 and returns its instruction cycle.
   task automatic issue(input logic [15:0] w, output int c);
      int k;
      k = 0;
      do begin
         @(posedge CLOCK);
         #1;
         k++;
      end while (INSTR_PHASE !== 2'h0 && k < 9);
      if (k >= 9) begin
         errors++;
         $display("ERROR %0t no instruction phase 0 seen", $time);
         report_and_stop();
      end
      c = icyc + 1;
      INSTR_WORD = w;
      @(posedge CLOCK);
      #1 INSTR_WORD = 16'hF000;
   endtask

   task automatic set_fp(input logic [13:0] v);
      @(posedge CLOCK);
      #1 FP_LOAD = 1;
      FP_DATA = v;
      @(posedge CLOCK);
      #1 FP_LOAD = 0;
      fp = v;
   endtask

   task automatic put(input logic [13:0] a0, input logic [7:0] d0);
      mdl[a0] = d0;
      i_mem.poke(a0, d0);
   endtask

   // Expects a read of s in cycle rc and, unless blocked, a write in wc.
   task automatic mv(input logic [13:0] s, t, input int rc, wc, input bit z,
                     input bit w);
      xr.push_back({rc[15:0], 2'b0, s, 8'h00});
      if (w) xw.push_back({wc[15:0], 2'b0, t, z ? 8'h00 : mdl[s]});
   endtask

   task automatic done(input string s);
      repeat (12) @(posedge CLOCK);
      #1 cmpq(aw, xw, "write");
      cmpq(ar, xr, "read");
      cmpq(ap, xp, "return");
      chk(nstd, xstd, "standard");
      chk(FRAME_POINTER, fp, "pointer");
      $display("test %s done", s);
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   initial begin
      repeat (20) @(posedge CLOCK);
      #1 chk({MEM_WE, MEM_RE, PC_LOAD, STD_PASS, FRAME_POINTER}, 0,
         "reset");
      RESETN = 1;
      // Extended words pass as standard ones while the extension is off.
      issue(16'hEA5A, n);
      issue(16'hE8C5, n);
      xstd += 2;
      FILE_OPERAND = 8'h10;
      done("disabled");
      chk(INDEXED_HIT, 0, "remap off");
      EXT_ENABLE = 1;
      repeat (4) @(posedge CLOCK);
      #1 chk(EXT_ACTIVE, 1, "enable");
      // Two pushes back to back, the second wrapping the pointer.
      set_fp(14'h0001);
      for (i = 0; i < 2; i++) begin
         r = $random(seed);
         issue({8'hEA, r[7:0]}, n);
         xw.push_back({n[15:0], 2'b0, fp, r[7:0]});
         mdl[fp] = r[7:0];
         fp = fp - 14'h0001;
      end
      done("push");
      // Add and subtract with return, each wrapping, then a NOP cycle.
      r = $random(seed);
      RETURN_STACK_TOP = r[20:0];
      set_fp(14'h3FF0);
      nop_seen = 0;
      issue(16'hE8FF, n);
      xp.push_back({n[15:0] + 16'h0001, 3'b0, r[20:0]});
      fp = fp + 14'h003F;
      issue(16'h0000, m);
      issue(16'hE9FF, n);
      xp.push_back({n[15:0] + 16'h0001, 3'b0, r[20:0]});
      fp = fp - 14'h003F;
      issue(16'h0000, m);
      chk(nop_seen, 1, "return nop");
      issue(16'h0000, m);
      xstd++;
      done("return");
      // A taken branch turns the following cycle into a NOP.
      issue(16'h0000, n);
      BRANCH_TAKEN = 1;
      @(posedge CLOCK);
      #1 BRANCH_TAKEN = 0;
      nop_seen = 0;
      issue(16'h0000, m);
      issue(16'hFABC, m);
      chk(nop_seen, 1, "branch nop");
      xstd++;
      done("branch");
      // Indexed to file with the largest offset, confined to 4k.
      set_fp(14'h1FF0);
      r = $random(seed);
      a = (fp + 14'h007F) & 14'h0FFF;
      put(a, r[7:0]);
      issue(16'hEB7F, n);
      issue({4'hF, r[19:8]}, m);
      mv(a, {2'b00, r[19:8]}, n, m, 0, 1);
      // Indexed to indexed: plain, indirect target, indirect source.
      for (i = 0; i < 3; i++) begin
         set_fp((i == 0) ? 14'h0F00 : 14'h0F70);
         zs = (i == 2) ? 7'h7A : 7'h05;
         zd = (i == 1) ? 7'h75 : 7'h10;
         r = $random(seed);
         a = fp + {7'h0, zs};
         b = fp + {7'h0, zd};
         put(a, r[7:0]);
         issue({9'h1D7, zs}, n);
         issue({4'hF, r[12:8], zd}, m);
         mv(a, b, n, m, i == 2, i != 1);
      end
      done("indexed moves");
      // Long move from the top address and from an indirect register.
      for (i = 0; i < 2; i++) begin
         set_fp((i == 0) ? 14'h3F80 : 14'h0FE0);
         zs = (i == 0) ? 7'h7F : 7'h03;
         r = $random(seed);
         a = fp + {7'h0, zs};
         b = {2'b10, r[19:8]};
         put(a, r[7:0]);
         issue(16'h0002, n);
         issue({4'hF, r[22:20], zs, b[13:12]}, m);
         issue({4'hF, b[11:0]}, m);
         mv(a, b, n + 1, m, i == 1, 1);
      end
      done("long move");
      // Operand remap at the limit, above it, and with the access bit set.
      for (i = 0; i < 3; i++) begin
         FILE_OPERAND = (i == 0) ? 8'h5F : (i == 1) ? 8'h60 : 8'h10;
         ACCESS_BIT = (i == 2);
         repeat (2) @(posedge CLOCK);
         #1 a = INDEXED_HIT ? INDEXED_ADDR : 14'h0;
         b = (i == 0) ? fp + 14'h005F : 14'h0;
         chk({INDEXED_HIT, a}, {i == 0, b}, "remap");
      end
      done("remap");
      report_and_stop();
   end
endmodule
